//--- rtl/spc_synth_regs.sv
// spc_synth_regs: synthesizer configuration bank with decoded controls.
// assumes requests come from the serial port logic on ref_clk (10 MHz),
// so they need no synchroniser.
`timescale 1ns/1ns
`default_nettype none
module spc_synth_regs
  import spc_pkg::*;
(
  input  wire logic     ref_clk, // 10 MHz bank clock
  input  wire logic     rst_b,   // async reset, active low
  input  wire spc_req_t req,     // word request from serial port
  output spc_rsp_t      rsp,     // read answer, one cycle later
  output spc_gate_t     gates,   // sub-block enables
  output spc_cfg_t      cfg      // decoded configuration
);

  logic [15:0] reg_q [SPC_NREG];
  logic        wr_sel [SPC_NREG];
  logic [2:0]  wr_ix;
  logic [2:0]  rd_ix;
  spc_rsp_t    next_rsp;
  spc_gate_t   next_gates;
  spc_cfg_t    next_cfg;

  // offset to slot, SPC_MISS when unmapped
  function automatic logic [2:0] addr_index(input logic [7:0] a);
    logic [2:0] ix;
    ix = SPC_MISS;
    for (int i = 0; i < SPC_NREG; i++)
    begin
      if (a == SPC_OFF_TAB[i])
        ix = 3'(i);
    end
    return ix;
  endfunction

  assign wr_ix = addr_index(req.addr);
  assign rd_ix = addr_index(req.addr);

  // the bank: one word per slot
  // configuration word storage
  for (genvar g = 0; g < SPC_NREG; g++)
  begin : g_word
    assign wr_sel[g] = req.wr && (wr_ix == 3'(g));
    spc_reg16 #(
      .RST   (SPC_RST_TAB[g]),
      .WMASK (SPC_WMASK_TAB[g])
    ) u_word (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .wr_sel  (wr_sel[g]),
      .wdata   (req.data),
      .q       (reg_q[g])
    );
  end

  // read path; an unmapped offset answers zero rather than stale data
  // unmapped reads zero
  always_comb
  begin
    next_rsp.valid = req.rd;
    next_rsp.data  = rsp.data;
    if (req.rd)
      next_rsp.data = (rd_ix == SPC_MISS) ? 16'h0000 : reg_q[rd_ix];
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      rsp <= '0;
    else
      rsp <= next_rsp;
  end

  // decode stored words into controls; registered so the analog side
  // never sees a decode glitch, at the cost of one cycle of lag
  always_comb
  begin
    logic [15:0] m;
    logic [15:0] p;
    logic [15:0] d;
    logic [15:0] o;
    m = reg_q[SPC_IX_MASK];
    p = reg_q[SPC_IX_PUMP];
    d = reg_q[SPC_IX_PFD];
    o = reg_q[SPC_IX_OSC];
    next_gates.quad_div_gate             = m[SPC_G_QUAD];
    next_gates.modulator_gate            = m[SPC_G_MODUL];
    next_gates.ext_double_lo_driver_gate = m[SPC_G_DBL_DRV];
    next_gates.ext_single_lo_driver_gate = m[SPC_G_SGL_DRV];
    next_gates.onchip_osc_single_lo_gate = m[SPC_G_SLO_OSC];
    next_gates.osc_selector_gate         = m[SPC_G_SELECT];
    next_gates.ref_buffer_gate           = m[SPC_G_REFBUF];
    next_gates.oscillator_gate           = m[SPC_G_OSC];
    next_gates.divider_gate              = m[SPC_G_DIVS];
    next_gates.pump_gate                 = m[SPC_G_PUMP];
    next_gates.osc_regulator_gate        = m[SPC_G_REG];
    next_cfg.int_value     = reg_q[SPC_IX_INT][SPC_INT_LSB +: 11];
    next_cfg.integer_mode  = reg_q[SPC_IX_INT][SPC_MODE_BIT];
    next_cfg.frac_value    = reg_q[SPC_IX_FRAC];
    next_cfg.modulus_value = reg_q[SPC_IX_MOD];
    next_cfg.pump_source_select = p[SPC_SRC_BIT];
    next_cfg.pump_coarse_scale  = p[SPC_SCALE_LSB +: 4];
    case (p[SPC_SCALE_LSB +: 4])
      SPC_SCALE_250:  next_cfg.pump_current_ua = SPC_UA_250;
      SPC_SCALE_500:  next_cfg.pump_current_ua = SPC_UA_500;
      SPC_SCALE_750:  next_cfg.pump_current_ua = SPC_UA_750;
      SPC_SCALE_1000: next_cfg.pump_current_ua = SPC_UA_1000;
      default:        next_cfg.pump_current_ua = 11'h000;
    endcase
    next_cfg.leak_sources = p[SPC_LEAK_DIR];
    next_cfg.leak_steps   = p[SPC_LEAK_LSB +: 5];
    next_cfg.ref_out_select      = d[SPC_RMUX_LSB +: 3];
    next_cfg.phase_detector_sign = d[SPC_SIGN_BIT];
    next_cfg.ref_ratio           = d[SPC_RATIO_LSB +: 3];
    next_cfg.regulator_resistor_four = o[SPC_R4_LSB +: 4];
    next_cfg.regulator_resistor_two  = o[SPC_R2_LSB +: 4];
    next_cfg.ext_lo_output_level     = o[SPC_LVL_LSB +: 2];
    next_cfg.ext_driver_halving      = o[SPC_HALF_BIT];
    // octal stage wins when both stages are enabled
    // total division eight, four or two
    if (o[SPC_OCT_BIT])
      next_cfg.lo_div_total = SPC_DIV_OCT;
    else if (o[SPC_QTR_BIT])
      next_cfg.lo_div_total = SPC_DIV_QTR;
    else
      next_cfg.lo_div_total = SPC_DIV_BASE;
    // flag only; the codes are still passed through as written
    // undefined select codes flagged
    next_cfg.select_illegal =
      (d[SPC_RMUX_LSB +: 3] > SPC_RMUX_MAX) ||
      (d[SPC_RATIO_LSB +: 3] > SPC_RATIO_MAX) ||
      (o[SPC_LVL_LSB +: 2] > SPC_LVL_MAX) ||
      (next_cfg.pump_current_ua == 11'h000);
  end

  // reset values follow the bank reset values
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gates <= spc_gate_t'(SPC_RST_TAB[SPC_IX_MASK][11:1]);
      cfg   <= '{int_value: 11'h02c, integer_mode: 1'b0,
                 frac_value: 16'h0128, modulus_value: 16'h0600,
                 pump_source_select: 1'b0, pump_coarse_scale: 4'h3,
                 pump_current_ua: SPC_UA_500, leak_sources: 1'b1,
                 leak_steps: 5'h06, ref_out_select: 3'h0,
                 phase_detector_sign: 1'b1, ref_ratio: 3'h3,
                 regulator_resistor_four: 4'h2,
                 regulator_resistor_two: 4'ha,
                 ext_lo_output_level: 2'h0, ext_driver_halving: 1'b0,
                 lo_div_total: SPC_DIV_BASE, select_illegal: 1'b0};
    end
    else
    begin
      gates <= next_gates;
      cfg   <= next_cfg;
    end
  end

  // checks: write at edge t, word at t+1, decoded control at t+2
  chk_int_write: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    req.wr && req.addr == SPC_OFF_INT |=> ##1
    cfg.int_value == $past(req.data[10:0], 2) &&
    cfg.integer_mode == $past(req.data[11], 2))
    else $error("integer divider word not applied");

  chk_frac_write: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    req.wr && req.addr == SPC_OFF_FRAC |=> ##1
    cfg.frac_value == $past(req.data, 2))
    else $error("fraction word not applied");

  chk_mod_readback: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    req.wr && req.addr == SPC_OFF_MOD ##1 req.rd && !req.wr &&
    req.addr == SPC_OFF_MOD |=> rsp.valid && rsp.data == $past(req.data, 2))
    else $error("modulus readback mismatch");

  chk_mask_fixed: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    req.rd && req.addr == SPC_OFF_MASK |=>
    rsp.data[15:12] == 4'hf && rsp.data[0])
    else $error("mask reserved bits changed");

  chk_quad_gate: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    req.wr && req.addr == SPC_OFF_MASK |=> ##1
    gates.quad_div_gate == $past(req.data[SPC_G_QUAD], 2) &&
    gates.modulator_gate == $past(req.data[SPC_G_MODUL], 2))
    else $error("quad or modulator gate wrong");

  chk_driver_gates: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    gates.ext_double_lo_driver_gate ==
    $past(reg_q[SPC_IX_MASK][SPC_G_DBL_DRV]) &&
    gates.onchip_osc_single_lo_gate ==
    $past(reg_q[SPC_IX_MASK][SPC_G_SLO_OSC]))
    else $error("lo driver gate wrong");

  chk_pump_gate: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    req.wr && req.addr == SPC_OFF_MASK |=> ##1
    gates.pump_gate == $past(req.data[SPC_G_PUMP], 2) &&
    gates.osc_regulator_gate == $past(req.data[SPC_G_REG], 2))
    else $error("core power gate wrong");

  chk_pump_source: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    $changed(reg_q[SPC_IX_PUMP][SPC_SRC_BIT]) |=>
    cfg.pump_source_select == $past(reg_q[SPC_IX_PUMP][SPC_SRC_BIT]))
    else $error("pump source not followed");

  chk_scale_map: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    cfg.pump_coarse_scale == SPC_SCALE_750 |->
    cfg.pump_current_ua == SPC_UA_750)
    else $error("coarse scale mapping wrong");

  chk_leak_split: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    req.wr && req.addr == SPC_OFF_PUMP |=> ##1
    cfg.leak_sources == $past(req.data[5], 2) &&
    cfg.leak_steps == $past(req.data[4:0], 2))
    else $error("leak field split wrong");

  chk_rmux_flag: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    cfg.ref_out_select == 3'h7 |-> cfg.select_illegal)
    else $error("undefined mux code not flagged");

  chk_sign_follow: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    req.wr && req.addr == SPC_OFF_PFD |=> ##1
    cfg.phase_detector_sign == $past(req.data[SPC_SIGN_BIT], 2))
    else $error("detector sign not applied");

  chk_ratio_flag: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    cfg.ref_ratio > SPC_RATIO_MAX |-> cfg.select_illegal)
    else $error("undefined ratio not flagged");

  chk_osc_low_fixed: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    reg_q[SPC_IX_OSC][2:0] == 3'h3 &&
    cfg.regulator_resistor_two == $past(reg_q[SPC_IX_OSC][11:8]))
    else $error("oscillator word fields wrong");

  chk_level_flag: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    cfg.ext_lo_output_level == 2'h3 |-> cfg.select_illegal)
    else $error("undefined level not flagged");

  chk_halving: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    cfg.ext_driver_halving == $past(reg_q[SPC_IX_OSC][SPC_HALF_BIT]))
    else $error("driver halving not followed");

  chk_div_eight: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    $past(reg_q[SPC_IX_OSC][SPC_OCT_BIT]) |-> cfg.lo_div_total == 4'h8)
    else $error("octal division not applied");

  chk_div_four: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    $past(reg_q[SPC_IX_OSC][4:3]) == 2'b01 |-> cfg.lo_div_total == 4'h4)
    else $error("quarter division not applied");

  chk_unmapped_zero: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    req.rd && addr_index(req.addr) == SPC_MISS |=>
    rsp.valid && rsp.data == 16'h0000)
    else $error("unmapped read not zero");

endmodule
`default_nettype wire

//--- rtl/spc_pkg.sv
// spc_pkg: map, reset values, field positions and carriers of the
// synthesizer configuration register bank.
// assumes the serial port logic delivers decoded word requests on ref_clk.
package spc_pkg;

  localparam int SPC_NREG = 7;

  // register offsets as seen by the serial port
  localparam logic [7:0] SPC_OFF_INT  = 8'h02;
  localparam logic [7:0] SPC_OFF_FRAC = 8'h03;
  localparam logic [7:0] SPC_OFF_MOD  = 8'h04;
  localparam logic [7:0] SPC_OFF_MASK = 8'h10;
  localparam logic [7:0] SPC_OFF_PUMP = 8'h20;
  localparam logic [7:0] SPC_OFF_PFD  = 8'h21;
  localparam logic [7:0] SPC_OFF_OSC  = 8'h22;

  // slot of each register in the bank
  localparam int SPC_IX_INT  = 0;
  localparam int SPC_IX_FRAC = 1;
  localparam int SPC_IX_MOD  = 2;
  localparam int SPC_IX_MASK = 3;
  localparam int SPC_IX_PUMP = 4;
  localparam int SPC_IX_PFD  = 5;
  localparam int SPC_IX_OSC  = 6;
  localparam logic [2:0] SPC_MISS = 3'h7;

  localparam logic [7:0] SPC_OFF_TAB [SPC_NREG] = '{SPC_OFF_INT,
    SPC_OFF_FRAC, SPC_OFF_MOD, SPC_OFF_MASK, SPC_OFF_PUMP, SPC_OFF_PFD,
    SPC_OFF_OSC};
  // reset values
  localparam logic [15:0] SPC_RST_TAB [SPC_NREG] = '{16'h002c, 16'h0128,
    16'h0600, 16'hf67f, 16'h0c26, 16'h000b, 16'h2a03};
  // writable bits; all others hold their reset value
  localparam logic [15:0] SPC_WMASK_TAB [SPC_NREG] = '{16'h0fff,
    16'hffff, 16'hffff, 16'h0ffe, 16'h7c3f, 16'h007f, 16'hfff8};

  // divider control fields
  localparam int SPC_INT_LSB   = 0;
  localparam int SPC_MODE_BIT  = 11;
  // block enable mask bits
  localparam int SPC_G_SLO_OSC = 11;
  localparam int SPC_G_MODUL   = 10;
  localparam int SPC_G_QUAD    = 9;
  localparam int SPC_G_DBL_DRV = 8;
  localparam int SPC_G_SGL_DRV = 7;
  localparam int SPC_G_SELECT  = 6;
  localparam int SPC_G_REFBUF  = 5;
  localparam int SPC_G_OSC     = 4;
  localparam int SPC_G_DIVS    = 3;
  localparam int SPC_G_PUMP    = 2;
  localparam int SPC_G_REG     = 1;
  // pump fields
  localparam int SPC_SRC_BIT   = 14;
  localparam int SPC_SCALE_LSB = 10;
  localparam int SPC_LEAK_LSB  = 0;
  localparam int SPC_LEAK_DIR  = 5;
  // phase detector fields
  localparam int SPC_RMUX_LSB  = 4;
  localparam int SPC_SIGN_BIT  = 3;
  localparam int SPC_RATIO_LSB = 0;
  // oscillator path fields
  localparam int SPC_R4_LSB    = 12;
  localparam int SPC_R2_LSB    = 8;
  localparam int SPC_LVL_LSB   = 6;
  localparam int SPC_HALF_BIT  = 5;
  localparam int SPC_OCT_BIT   = 4;
  localparam int SPC_QTR_BIT   = 3;

  // coarse scale codes and currents in uA
  localparam logic [3:0]  SPC_SCALE_250  = 4'h1;
  localparam logic [3:0]  SPC_SCALE_500  = 4'h3;
  localparam logic [3:0]  SPC_SCALE_750  = 4'h7;
  localparam logic [3:0]  SPC_SCALE_1000 = 4'hf;
  localparam logic [10:0] SPC_UA_250     = 11'h0fa;
  localparam logic [10:0] SPC_UA_500     = 11'h1f4;
  localparam logic [10:0] SPC_UA_750     = 11'h2ee;
  localparam logic [10:0] SPC_UA_1000    = 11'h3e8;
  // highest defined codes of the select fields
  localparam logic [2:0] SPC_RMUX_MAX  = 3'h6;
  localparam logic [2:0] SPC_RATIO_MAX = 3'h4;
  localparam logic [1:0] SPC_LVL_MAX   = 2'h2;
  // total lo path division
  localparam logic [3:0] SPC_DIV_BASE = 4'h2;
  localparam logic [3:0] SPC_DIV_QTR  = 4'h4;
  localparam logic [3:0] SPC_DIV_OCT  = 4'h8;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] data;
  } spc_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } spc_rsp_t;

  typedef struct packed {
    logic onchip_osc_single_lo_gate;
    logic modulator_gate;
    logic quad_div_gate;
    logic ext_double_lo_driver_gate;
    logic ext_single_lo_driver_gate;
    logic osc_selector_gate;
    logic ref_buffer_gate;
    logic oscillator_gate;
    logic divider_gate;
    logic pump_gate;
    logic osc_regulator_gate;
  } spc_gate_t;

  typedef struct packed {
    logic [10:0] int_value;
    logic        integer_mode;
    logic [15:0] frac_value;
    logic [15:0] modulus_value;
    logic        pump_source_select;
    logic [3:0]  pump_coarse_scale;
    logic [10:0] pump_current_ua;
    logic        leak_sources;
    logic [4:0]  leak_steps;
    logic [2:0]  ref_out_select;
    logic        phase_detector_sign;
    logic [2:0]  ref_ratio;
    logic [3:0]  regulator_resistor_four;
    logic [3:0]  regulator_resistor_two;
    logic [1:0]  ext_lo_output_level;
    logic        ext_driver_halving;
    logic [3:0]  lo_div_total;
    logic        select_illegal;
  } spc_cfg_t;

endpackage

//--- rtl/spc_reg16.sv
// spc_reg16: one 16-bit configuration word with fixed reserved bits.
// assumes wr_sel is a one-cycle strobe on ref_clk.
`timescale 1ns/1ns
`default_nettype none
module spc_reg16 #(
  parameter logic [15:0] RST   = 16'h0000,
  parameter logic [15:0] WMASK = 16'hffff
) (
  input  wire logic        ref_clk, // bank clock
  input  wire logic        rst_b,   // async reset, active low
  input  wire logic        wr_sel,  // write this word
  input  wire logic [15:0] wdata,   // write data
  output logic      [15:0] q        // stored word
);

  logic [15:0] next_q;

  // reserved bits are reloaded from the reset value on every write
  always_comb
  begin
    next_q = q;
    if (wr_sel)
    begin
      next_q = (wdata & WMASK) | (RST & ~WMASK);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      q <= RST;
    else
      q <= next_q;
  end

endmodule
`default_nettype wire

//--- dv/spc_host.sv
// spc_host: host side model issuing word requests to the config bank.
// assumes one bench process calls put and idle at a time.
`timescale 1ns/1ns
`default_nettype none
module spc_host
  import spc_pkg::*;
(
  input  wire logic     ref_clk, // bank clock
  output spc_req_t      req      // word request to the bank
);
  initial req = '0;

  // strobe down; address and data flip so stale values never look valid
  task automatic idle();
    @(posedge ref_clk);
    req <= '{1'b0, 1'b0, ~req.addr, ~req.data};
  endtask

  // optional idle gap models a slow host, then one request for one edge
  task automatic put(input logic wr, input logic rd, input logic [7:0] a,
                     input logic [15:0] d, input int gap);
    repeat (gap) idle();
    @(posedge ref_clk);
    req <= '{wr, rd, a, d};
  endtask

  // legal select codes
  // undefined codes are folded onto defined ones before they are sent
  function automatic logic [15:0] tidy(input logic [7:0] a,
                                       input logic [15:0] d);
    logic [15:0] t;
    t = d;
    if (a == SPC_OFF_PUMP)
      t[13:10] = 4'hf >> (2'h3 - d[11:10]);
    if (a == SPC_OFF_PFD && t[6:4] == 3'h7)
      t[6:4] = 3'h6;
    if (a == SPC_OFF_PFD && t[2:0] > 3'h4)
      t[2:0] = 3'h4;
    if (a == SPC_OFF_OSC && t[7:6] == 2'h3)
      t[7:6] = 2'h2;
    return t;
  endfunction
endmodule
`default_nettype wire

//--- dv/spc_synth_regs_bench.sv
// spc_synth_regs_bench: self-checking bench of the config bank.
// assumes the host model drives requests; reads are scored from a queue.
`timescale 1ns/1ns
`default_nettype none
module spc_synth_regs_bench;
  import spc_pkg::*;
  logic     ref_clk;
  logic     rst_b;
  spc_req_t req;
  spc_rsp_t rsp;
  spc_gate_t gates;
  spc_cfg_t cfg;
  int       errors;
  int       samples_checked;
  integer   seed;
  logic [15:0] exp_reg [7];
  logic [15:0] exp_q [$];
  localparam logic [7:0] OFFS [7] = '{8'h02, 8'h03, 8'h04, 8'h10,
    8'h20, 8'h21, 8'h22};
  localparam logic [15:0] RST_VAL [7] = '{16'h002c, 16'h0128, 16'h0600,
    16'hf67f, 16'h0c26, 16'h000b, 16'h2a03};
  // reserved bits keep their reset value, so only these can change
  localparam logic [15:0] WR_BITS [7] = '{16'h0fff, 16'hffff, 16'hffff,
    16'h0ffe, 16'h7c3f, 16'h007f, 16'hfff8};

  spc_synth_regs u_spc_synth_regs (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .req     (req),
    .rsp     (rsp),
    .gates   (gates),
    .cfg     (cfg)
  );

  spc_host u_spc_host (
    .ref_clk (ref_clk),
    .req     (req)
  );

  always #50 ref_clk = ~ref_clk;

  task automatic chk(input logic [95:0] got, input logic [95:0] want,
                     input string what);
    samples_checked++;
    if (got !== want)
    begin
      errors++;
      $display("BAD t=%0t %s got %h want %h", $time, what, got, want);
    end
  endtask

  function automatic int slot(input logic [7:0] a);
    foreach (OFFS[i])
      if (OFFS[i] === a)
        return i;
    return -1;
  endfunction

  // expected decode of the model words
  function automatic spc_cfg_t dec();
    spc_cfg_t c;
    logic [15:0] p;
    logic [15:0] f;
    logic [15:0] o;
    p = exp_reg[4];
    f = exp_reg[5];
    o = exp_reg[6];
    c.int_value = exp_reg[0][10:0];
    c.integer_mode = exp_reg[0][11];
    c.frac_value = exp_reg[1];
    c.modulus_value = exp_reg[2];
    c.pump_source_select = p[14];
    c.pump_coarse_scale = p[13:10];
    case (p[13:10])
      4'h1: c.pump_current_ua = 11'h0fa;
      4'h3: c.pump_current_ua = 11'h1f4;
      4'h7: c.pump_current_ua = 11'h2ee;
      4'hf: c.pump_current_ua = 11'h3e8;
      default: c.pump_current_ua = 11'h000;
    endcase
    c.leak_sources = p[5];
    c.leak_steps = p[4:0];
    c.ref_out_select = f[6:4];
    c.phase_detector_sign = f[3];
    c.ref_ratio = f[2:0];
    c.regulator_resistor_four = o[15:12];
    c.regulator_resistor_two = o[11:8];
    c.ext_lo_output_level = o[7:6];
    c.ext_driver_halving = o[5];
    c.lo_div_total = o[4] ? 4'h8 : (o[3] ? 4'h4 : 4'h2);
    c.select_illegal = f[6:4] == 3'h7 || f[2:0] > 3'h4 ||
      o[7:6] == 2'h3 || c.pump_current_ua == 11'h000;
    return c;
  endfunction

  // one request; the expected read word is noted before the bank sees it
  task automatic acc(input logic wr, input logic rd, input logic [7:0] a,
                     input logic [15:0] d, input int gap);
    int s;
    s = slot(a);
    if (rd)
      exp_q.push_back(s >= 0 ? exp_reg[s] : 16'h0000);
    if (wr && s >= 0)
      exp_reg[s] = (exp_reg[s] & ~WR_BITS[s]) | (d & WR_BITS[s]);
    u_spc_host.put(wr, rd, a, d, gap);
  endtask

  // controls lag the word by one edge, so wait past both before looking
  task automatic sync();
    u_spc_host.idle();
    repeat (2) @(posedge ref_clk);
    #1;
    chk(96'(cfg), 96'(dec()), "cfg");
    chk(96'(gates), 96'(exp_reg[3][11:1]), "gates");
  endtask

  task automatic read_all(input int gap);
    foreach (OFFS[i])
      acc(1'b0, 1'b1, OFFS[i], 16'h0000, gap);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // read answers are scored in the order they were asked
  always @(posedge ref_clk)
  begin
    if (rst_b === 1'b1 && rsp.valid === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        errors++;
        $display("BAD t=%0t answer with no read pending", $time);
      end
      else
        chk(96'(rsp.data), 96'(exp_q.pop_front()), "read data");
    end
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    #(20000 * 100);
    errors++;
    $display("BAD t=%0t watchdog expired", $time);
    test_done();
  end

  initial
  begin
    logic [31:0] r;
    logic [7:0]  a;
    logic [15:0] d;
    ref_clk = 1'b0;
    rst_b = 1'b0;
    errors = 0;
    samples_checked = 0;
    seed = 32'h488c;
    foreach (exp_reg[i])
      exp_reg[i] = RST_VAL[i];
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    // reset words back to back, and their decode
    read_all(0);
    sync();
    $display("test reset done");
    // walking one over the enable mask, reserved bits included
    for (int i = 0; i < 16; i++)
    begin
      acc(1'b1, 1'b0, 8'h10, 16'h0001 << i, 0);
      sync();
    end
    read_all(1);
    $display("test gates done");
    // each of the four defined coarse scale codes, source select and leak direction
    for (int i = 0; i < 4; i++)
    begin
      d = {1'b0, i[0], 4'hf >> (3 - i), 4'h0, i[1], i[0], 4'h5};
      acc(1'b1, 1'b1, 8'h20, d ^ 16'h8000, i);
      sync();
    end
    $display("test pump done");
    // every ref mux, ratio, level and lo divider setting
    for (int i = 0; i < 7; i++)
    begin
      // mux code walks 0..6 only; sign bit kept apart from the mux field
      d = 16'h0080 | 16'((i << 4) | ((i % 2) << 3) | (i % 5));
      acc(1'b1, 1'b0, 8'h21, d, 0);
      d = {4'(i), 4'(~i), 2'(i % 3), 3'(i), 3'h5};
      acc(1'b1, 1'b0, 8'h22, d, 0);
      sync();
    end
    read_all(0);
    $display("test selects done");
    // unmapped places: writes vanish, reads answer zero
    acc(1'b1, 1'b0, 8'h05, 16'hffff, 0);
    acc(1'b1, 1'b1, 8'h01, 16'hffff, 0);
    acc(1'b0, 1'b1, 8'hff, 16'h0000, 0);
    read_all(0);
    sync();
    $display("test unmapped done");
    // write and read together return the old word
    acc(1'b1, 1'b1, 8'h03, 16'ha5c3, 0);
    acc(1'b1, 1'b1, 8'h03, 16'h5a3c, 0);
    // write then read straight after returns the new word
    acc(1'b1, 1'b0, 8'h04, 16'h3c5a, 0);
    acc(1'b0, 1'b1, 8'h04, 16'h0000, 0);
    acc(1'b1, 1'b1, 8'h04, 16'hffff, 0);
    acc(1'b1, 1'b1, 8'h02, 16'hffff, 0);
    sync();
    $display("test overlap done");
    // random legal traffic at varying host pace
    for (int i = 0; i < 60; i++)
    begin
      r = $random(seed);
      a = OFFS[r[31:8] % 7];
      d = u_spc_host.tidy(a, r[23:8]);
      acc(r[0], r[1] | ~r[0], a, d, int'(r[3:2]));
    end
    read_all(0);
    sync();
    chk(96'(exp_q.size()), 96'h0, "pending reads");
    $display("test random done");
    test_done();
  end
endmodule
`default_nettype wire
